// [logic/sqw_defines.svh]
// register offsets, field positions, reset values and counts of the
// source-queue weight and soft error register group
// assumes byte addressing of 32-bit registers over a 12-bit offset
`ifndef SQW_DEFINES_SVH
`define SQW_DEFINES_SVH

// register byte offsets
`define SQW_OFS_THRESH       12'hf10
`define SQW_OFS_WEIGHT       12'hf14
`define SQW_OFS_CNT_FIRST    12'hf18
`define SQW_OFS_CNT_SECOND   12'hf1c
`define SQW_OFS_CNT_RETRY    12'hf2c
`define SQW_OFS_INJECT       12'hf30

// egress threshold fields
`define SQW_THR_LO_LSB       0
`define SQW_THR_HI_LSB       16
`define SQW_THR_W            8
`define SQW_THR_RST_UP       8'hff
`define SQW_THR_RST_DN       8'h00
`define SQW_THR_WMASK        32'h00ff00ff

// source queue weights
`define SQW_NUM_SRC          8
`define SQW_WGT_W            3
`define SQW_WGT_STRIDE       4
`define SQW_WGT_RST          3'h0
`define SQW_WGT_WMASK        32'h77777777

// soft error counters
`define SQW_NUM_CNT          8
`define SQW_CNT_W            8
`define SQW_CNT_RST          8'h00
`define SQW_CNT_MAX          8'hff
`define SQW_CNT_RETRY_LSB    16

// soft error injection
`define SQW_NUM_MEM          4
`define SQW_INJ_STRIDE       3
`define SQW_INJ_ONE          0
`define SQW_INJ_TWO          1
`define SQW_INJ_FIELD        2
`define SQW_INJ_W            12
`define SQW_INJ_RST          12'h000
`define SQW_INJ_WMASK        32'h00000fff

// port holding the counters and injection control
`define SQW_COMMON_PORT      0

`endif

// [logic/sqw_pkg.sv]
// types shared by the source-queue weight and soft error register group
// assumes sqw_defines.svh is on the include path
`include "sqw_defines.svh"

package sqw_pkg;

	typedef logic [`SQW_WGT_W-1:0] sqw_weight_type;
	typedef sqw_weight_type [`SQW_NUM_SRC-1:0] sqw_weight_arr_type;
	typedef logic [`SQW_CNT_W-1:0] sqw_count_type;
	typedef logic [`SQW_THR_W-1:0] sqw_thresh_type;
	typedef logic [`SQW_INJ_W-1:0] sqw_inject_type;
	typedef logic [11:0] sqw_addr_type;

	typedef enum logic {
		SQW_SCHED_IDLE,
		SQW_SCHED_BURST
	} sqw_sched_state_type;

endpackage

// [logic/sqw_cfg_if.sv]
// carries the register-held settings from the register bank to the
// weighted source scheduler and to the error injection sequencer
// assumes all parties run on the same core clock
`timescale 1ns/1ps

interface sqw_cfg_if;
	import sqw_pkg::*;

	sqw_weight_arr_type weights;
	sqw_inject_type     inject;

	modport regs_mp  (output weights, output inject);
	modport sched_mp (input weights);
	modport inj_mp   (input inject);
endinterface

// [logic/sqw_weight_sched.sv]
// weighted back-to-back scheduler among the source queues feeding one
// downstream port
// assumes tlp_done_i pulses once per TLP issued by the granted queue
`timescale 1ns/1ps
`include "sqw_defines.svh"

module sqw_weight_sched (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// settings
	sqw_cfg_if.sched_mp                 cfg,
	// source queues
	input  wire logic [`SQW_NUM_SRC-1:0] src_req_i,
	input  wire logic [2:0]             dest_port_i,
	input  wire logic                   tlp_done_i,
	// grant
	output logic [`SQW_NUM_SRC-1:0]     grant_o
);
	import sqw_pkg::*;

	sqw_sched_state_type  state_q, state_d;
	logic [2:0]           owner_q, owner_d;
	sqw_weight_type       cnt_q, cnt_d;
	logic [`SQW_NUM_SRC-1:0] eligible, owner_hot;
	logic                 others_wait, quota_done;
	logic [2:0]           next_owner;

	// round-robin pick starting after the previous owner
	function automatic logic [2:0] rr_next(input logic [2:0] last,
		input logic [`SQW_NUM_SRC-1:0] req);
		logic [2:0] idx;
		logic       found;
		rr_next = last;
		found = 1'b0;
		for (int i = 1; i <= `SQW_NUM_SRC; i++) begin
			idx = 3'(last + 3'(i));
			if (!found && req[idx]) begin
				rr_next = idx;
				found = 1'b1;
			end
		end
	endfunction

	// a port never sends to itself, so its own slot never competes
	assign eligible    = src_req_i & ~(`SQW_NUM_SRC'(1) << dest_port_i);
	assign owner_hot   = `SQW_NUM_SRC'(1) << owner_q;
	assign others_wait = |(eligible & ~owner_hot);
	assign quota_done  = cnt_q >= cfg.weights[owner_q];
	assign next_owner  = rr_next(owner_q, eligible);
	assign grant_o     = (state_q == SQW_SCHED_BURST) ?
		(owner_hot & eligible) : '0;

	always_comb begin
		state_d = state_q;
		owner_d = owner_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			SQW_SCHED_IDLE: begin
				if (|eligible) begin
					owner_d = next_owner;
					cnt_d   = `SQW_WGT_RST;
					state_d = SQW_SCHED_BURST;
				end
			end
			SQW_SCHED_BURST: begin
				if (!eligible[owner_q]) begin
					state_d = SQW_SCHED_IDLE;
				end else if (tlp_done_i) begin
					// a spent quota ends the burst only when someone else is waiting
					if (quota_done && others_wait) begin
						state_d = SQW_SCHED_IDLE;
					end else if (!quota_done) begin
						cnt_d = cnt_q + 3'h1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= SQW_SCHED_IDLE;
			owner_q <= 3'h0;
			cnt_q   <= `SQW_WGT_RST;
		end else begin
			state_q <= state_d;
			owner_q <= owner_d;
			cnt_q   <= cnt_d;
		end
	end
endmodule

// [logic/sqw_err_inject.sv]
// turns each change of an injection toggle bit into one error request
// assumes the memories act on a one-cycle request pulse
`timescale 1ns/1ps
`include "sqw_defines.svh"

module sqw_err_inject (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// settings
	sqw_cfg_if.inj_mp                   cfg,
	// requests to the memories
	output logic [`SQW_NUM_MEM-1:0]     inj_single_o,
	output logic [`SQW_NUM_MEM-1:0]     inj_double_o,
	output logic [`SQW_NUM_MEM-1:0]     inj_data_o
);
	import sqw_pkg::*;

	sqw_inject_type prev_q;

	// prev tracks the register so a toggle fires exactly once
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prev_q <= `SQW_INJ_RST;
		end else begin
			prev_q <= cfg.inject;
		end
	end

	for (genvar m = 0; m < `SQW_NUM_MEM; m++) begin : g_mem
		localparam int B = m * `SQW_INJ_STRIDE;
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				inj_single_o[m] <= 1'b0;
				inj_double_o[m] <= 1'b0;
				inj_data_o[m]   <= 1'b0;
			end else begin
				inj_single_o[m] <= cfg.inject[B + `SQW_INJ_ONE] ^
					prev_q[B + `SQW_INJ_ONE];
				inj_double_o[m] <= cfg.inject[B + `SQW_INJ_TWO] ^
					prev_q[B + `SQW_INJ_TWO];
				inj_data_o[m]   <= cfg.inject[B + `SQW_INJ_FIELD];
			end
		end
	end
endmodule

// [logic/sqw_regs.sv]
// register bank for egress thresholds, source-queue weights, soft error
// counters and soft error injection of one switch port
// assumes a single-cycle configuration access port and an eeprom
// preload port on the core clock; counter and inject events are pulses
`timescale 1ns/1ps
`include "sqw_defines.svh"

module sqw_regs #(
	parameter int PORT_NUM    = 0,
	parameter bit IS_UPSTREAM = 1'b1
) (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        sys_rst_i,
	// configuration access
	input  wire logic                        cfg_wr_i,
	input  wire logic                        cfg_rd_i,
	input  wire sqw_pkg::sqw_addr_type       cfg_addr_i,
	input  wire logic [3:0]                  cfg_be_i,
	input  wire logic [31:0]                 cfg_wdata_i,
	output logic [31:0]                      cfg_rdata_o,
	output logic                             cfg_ack_o,
	// eeprom or i2c preload of sticky fields
	input  wire logic                        ee_wr_i,
	input  wire sqw_pkg::sqw_addr_type       ee_addr_i,
	input  wire logic [31:0]                 ee_data_i,
	// arbitration table load
	input  wire logic                        arb_load_i,
	input  wire sqw_pkg::sqw_weight_arr_type arb_weights_i,
	// egress scheduling
	input  wire sqw_pkg::sqw_thresh_type     egress_tlp_count_i,
	output logic                             egress_sched_en_o,
	// source queue scheduling
	input  wire logic [`SQW_NUM_SRC-1:0]     src_req_i,
	input  wire logic [2:0]                  dest_port_i,
	input  wire logic                        tlp_done_i,
	output logic [`SQW_NUM_SRC-1:0]          grant_o,
	// soft error events and injection
	input  wire logic [`SQW_NUM_CNT-1:0]     sbe_event_i,
	output logic [`SQW_NUM_MEM-1:0]          inj_single_o,
	output logic [`SQW_NUM_MEM-1:0]          inj_double_o,
	output logic [`SQW_NUM_MEM-1:0]          inj_data_o
);
	import sqw_pkg::*;

	localparam bit HAS_COMMON = (PORT_NUM == `SQW_COMMON_PORT);
	localparam sqw_thresh_type THR_RST =
		IS_UPSTREAM ? `SQW_THR_RST_UP : `SQW_THR_RST_DN;

	sqw_cfg_if cfg_bus ();

	// register state
	sqw_thresh_type     thr_lo_q;
	sqw_thresh_type     thr_hi_q;
	sqw_weight_arr_type weight_q;
	sqw_inject_type     inject_q;
	sqw_count_type      cnt_q [`SQW_NUM_CNT];
	logic               sched_en_q;

	// merged write path: configuration access has priority over preload
	logic               wr_en;
	sqw_addr_type       wr_addr;
	logic [3:0]         wr_be;
	logic [31:0]        wr_data;
	logic [31:0]        thr_word;
	logic [31:0]        weight_word;
	logic [31:0]        inject_word;
	logic [31:0]        thr_next;
	logic [31:0]        weight_next;
	logic [31:0]        inject_next;
	logic [31:0]        cnt_first_word;
	logic [31:0]        cnt_second_word;
	logic [31:0]        cnt_retry_word;
	logic [31:0]        rd_word;
	logic               wr_thr;
	logic               wr_weight;
	logic               wr_inject;
	logic               thr_hit_hi;
	logic               thr_below_lo;
	logic               sched_stop;
	logic               sched_resume;
	// read-side register selects
	logic               sel_thr;
	logic               sel_weight;
	logic               sel_cnt_first;
	logic               sel_cnt_second;
	logic               sel_cnt_retry;
	logic               sel_inject;

	// address match on the word, used for writes and reads alike
	function automatic logic hit(input sqw_addr_type a,
		input sqw_addr_type ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	// byte-lane merge limited to the writable bits of a register
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be,
		input logic [31:0] wmask);
		logic [31:0] lane;
		lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old & ~(lane & wmask)) | (nw & lane & wmask);
	endfunction

	// preload carries whole words only, so its lanes are all enabled
	assign wr_en   = cfg_wr_i | ee_wr_i;
	assign wr_addr = cfg_wr_i ? cfg_addr_i : ee_addr_i;
	assign wr_be   = cfg_wr_i ? cfg_be_i : 4'hf;
	assign wr_data = cfg_wr_i ? cfg_wdata_i : ee_data_i;

	// reserved downstream threshold bits stay zero
	assign wr_thr    = wr_en && IS_UPSTREAM &&
		hit(wr_addr, `SQW_OFS_THRESH);
	assign wr_weight = wr_en && hit(wr_addr, `SQW_OFS_WEIGHT);
	assign wr_inject = wr_en && HAS_COMMON &&
		hit(wr_addr, `SQW_OFS_INJECT);

	// packed views of the registers
	always_comb begin
		thr_word = '0;
		thr_word[`SQW_THR_LO_LSB +: `SQW_THR_W] = thr_lo_q;
		thr_word[`SQW_THR_HI_LSB +: `SQW_THR_W] = thr_hi_q;
		weight_word = '0;
		for (int i = 0; i < `SQW_NUM_SRC; i++) begin
			weight_word[i*`SQW_WGT_STRIDE +: `SQW_WGT_W] = weight_q[i];
		end
	end

	assign inject_word = {{(32-`SQW_INJ_W){1'b0}}, inject_q};
	assign thr_next    = merge(thr_word, wr_data, wr_be, `SQW_THR_WMASK);
	assign weight_next = merge(weight_word, wr_data, wr_be,
		`SQW_WGT_WMASK);
	assign inject_next = merge(inject_word, wr_data, wr_be,
		`SQW_INJ_WMASK);

	// threshold register, upstream only
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			thr_lo_q <= THR_RST;
			thr_hi_q <= THR_RST;
		end else if (wr_thr) begin
			thr_lo_q <= thr_next[`SQW_THR_LO_LSB +: `SQW_THR_W];
			thr_hi_q <= thr_next[`SQW_THR_HI_LSB +: `SQW_THR_W];
		end
	end

	// weights: a table load overrides a same-cycle register write
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			weight_q <= '{default: `SQW_WGT_RST};
		end else if (arb_load_i) begin
			weight_q <= arb_weights_i;
		end else if (wr_weight) begin
			for (int i = 0; i < `SQW_NUM_SRC; i++) begin
				weight_q[i] <=
					weight_next[i*`SQW_WGT_STRIDE +: `SQW_WGT_W];
			end
		end
	end

	// injection control; on other ports it stays zero so no toggle fires
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			inject_q <= `SQW_INJ_RST;
		end else if (wr_inject) begin
			inject_q <= inject_next[`SQW_INJ_W-1:0];
		end
	end

	// egress hysteresis: off at or above upper, back on below lower
	assign thr_hit_hi   = egress_tlp_count_i >= thr_hi_q;
	assign thr_below_lo = egress_tlp_count_i < thr_lo_q;

	// downstream thresholds are reserved, so those ports never stop
	assign sched_stop   = IS_UPSTREAM && sched_en_q && thr_hit_hi;
	assign sched_resume = IS_UPSTREAM && !sched_en_q && thr_below_lo;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sched_en_q <= 1'b1;
		end else if (sched_stop) begin
			sched_en_q <= 1'b0;
		end else if (sched_resume) begin
			sched_en_q <= 1'b1;
		end
	end

	assign egress_sched_en_o = sched_en_q;

	// soft error counters; saturating keeps a flood from reading as few
	for (genvar c = 0; c < `SQW_NUM_CNT; c++) begin : g_cnt
		logic at_max;
		assign at_max = (cnt_q[c] == `SQW_CNT_MAX);
		always_ff @(posedge clk_i) begin
			if (sys_rst_i || !HAS_COMMON) begin
				cnt_q[c] <= `SQW_CNT_RST;
			end else if (sbe_event_i[c] && !at_max) begin
				cnt_q[c] <= cnt_q[c] + 8'h01;
			end
		end
	end

	// counter words: 0..3 first, 4..5 second, 6..7 top of retry word
	assign cnt_first_word  = {cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]};
	assign cnt_second_word = {16'h0000, cnt_q[5], cnt_q[4]};
	assign cnt_retry_word  = {cnt_q[7], cnt_q[6],
		{`SQW_CNT_RETRY_LSB{1'b0}}};

	// read decode; unmapped or absent registers read as zero
	assign sel_thr        = hit(cfg_addr_i, `SQW_OFS_THRESH);
	assign sel_weight     = hit(cfg_addr_i, `SQW_OFS_WEIGHT);
	assign sel_cnt_first  = HAS_COMMON &&
		hit(cfg_addr_i, `SQW_OFS_CNT_FIRST);
	assign sel_cnt_second = HAS_COMMON &&
		hit(cfg_addr_i, `SQW_OFS_CNT_SECOND);
	assign sel_cnt_retry  = HAS_COMMON &&
		hit(cfg_addr_i, `SQW_OFS_CNT_RETRY);
	assign sel_inject     = HAS_COMMON &&
		hit(cfg_addr_i, `SQW_OFS_INJECT);

	// selects are one-hot, so an and-or mux needs no priority chain
	assign rd_word =
		({32{sel_thr}}        & thr_word)        |
		({32{sel_weight}}     & weight_word)     |
		({32{sel_cnt_first}}  & cnt_first_word)  |
		({32{sel_cnt_second}} & cnt_second_word) |
		({32{sel_cnt_retry}}  & cnt_retry_word)  |
		({32{sel_inject}}     & inject_word);

	// writes are answered too, so one handshake paces every configuration access; preload writes get no ack
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_rdata_o <= '0;
			cfg_ack_o   <= 1'b0;
		end else begin
			cfg_ack_o <= cfg_rd_i | cfg_wr_i;
			if (cfg_rd_i) begin
				cfg_rdata_o <= rd_word;
			end
		end
	end

	assign cfg_bus.weights = weight_q;
	assign cfg_bus.inject  = inject_q;

	sqw_weight_sched u_sched (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.cfg         (cfg_bus.sched_mp),
		.src_req_i   (src_req_i),
		.dest_port_i (dest_port_i),
		.tlp_done_i  (tlp_done_i),
		.grant_o     (grant_o)
	);

	sqw_err_inject u_inject (
		.clk_i        (clk_i),
		.sys_rst_i    (sys_rst_i),
		.cfg          (cfg_bus.inj_mp),
		.inj_single_o (inj_single_o),
		.inj_double_o (inj_double_o),
		.inj_data_o   (inj_data_o)
	);
endmodule

// [tb/sqw_regs_asserts.sv]
// port assertions for the weight and soft error register group
// assumes bind into sqw_regs; one core clock, sync active-high reset
`timescale 1ns/1ps

module sqw_regs_asserts (
	// clock and reset
	input wire logic                    clk_i,
	input wire logic                    sys_rst_i,
	// register and preload access
	input wire logic                    cfg_wr_i,
	input wire logic                    cfg_rd_i,
	input wire logic                    ee_wr_i,
	input wire logic [31:0]             cfg_rdata_o,
	input wire logic                    cfg_ack_o,
	// scheduling
	input wire sqw_pkg::sqw_thresh_type egress_tlp_count_i,
	input wire logic                    egress_sched_en_o,
	input wire logic [7:0]              src_req_i,
	input wire logic [2:0]              dest_port_i,
	input wire logic [7:0]              grant_o,
	// injection
	input wire logic [3:0]              inj_single_o,
	input wire logic [3:0]              inj_double_o
);
	import sqw_pkg::*;
	logic acc;
	logic wr_any;
	assign acc = cfg_wr_i | cfg_rd_i;
	assign wr_any = cfg_wr_i | ee_wr_i;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// guards against $past looking into a reset cycle
	sequence s_settled;
		!$past(sys_rst_i);
	endsequence
	// a count of ffh is at or above any upper threshold
	sequence s_full;
		egress_sched_en_o && egress_tlp_count_i == 8'hff;
	endsequence

	AST_ACK: assert property (s_settled |-> cfg_ack_o == $past(acc))
		else $error("ack does not follow access by one cycle");
	AST_RD_HOLD: assert property (s_settled ##0 !$past(cfg_rd_i)
		|-> $stable(cfg_rdata_o)) else $error("read data moved");
	AST_THR_STOP: assert property (s_full |=> !egress_sched_en_o)
		else $error("scheduling not stopped at full count");
	AST_THR_RESUME: assert property (s_settled ##0
		$rose(egress_sched_en_o) |-> $past(egress_tlp_count_i) != 8'hff)
		else $error("scheduling resumed at full count");
	AST_GRANT_ONEHOT: assert property ($onehot0(grant_o))
		else $error("more than one grant");
	AST_GRANT_REQ: assert property ((grant_o & ~src_req_i) == 8'h00)
		else $error("grant without request");
	AST_DEST_EXCL: assert property (!grant_o[dest_port_i])
		else $error("grant to destination slot");
	AST_INJ_ONE: assert property (inj_single_o != 4'h0 |=>
		(inj_single_o & $past(inj_single_o)) == 4'h0)
		else $error("single injection longer than one cycle");
	AST_INJ_CAUSE: assert property ((inj_single_o | inj_double_o) != 4'h0
		|-> $past(wr_any, 2)) else $error("injection without write");
endmodule

bind sqw_regs sqw_regs_asserts u_sqw_chk (
	.clk_i, .sys_rst_i, .cfg_wr_i, .cfg_rd_i, .ee_wr_i, .cfg_rdata_o,
	.cfg_ack_o, .egress_tlp_count_i, .egress_sched_en_o, .src_req_i,
	.dest_port_i, .grant_o, .inj_single_o, .inj_double_o
);

// [tb/test_source_queue_weight_soft_error_regs.sv]
// self-checking bench of the weight and soft error register group
// assumes the port-0 upstream instance and the bound port checker
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	failures++; \
	$display("MISMATCH %0t got %h exp %h", $time, (g), (e)); \
end end

module test_source_queue_weight_soft_error_regs;
	import sqw_pkg::*;

	logic               clk_i, sys_rst_i, cfg_wr_i, cfg_rd_i, ee_wr_i;
	logic               arb_load_i, tlp_done_i, cfg_ack_o, egress_sched_en_o;
	sqw_addr_type       cfg_addr_i, ee_addr_i;
	logic [3:0]         cfg_be_i, inj_single_o, inj_double_o, inj_data_o;
	logic [31:0]        cfg_wdata_i, ee_data_i, cfg_rdata_o, v, w;
	sqw_weight_arr_type arb_weights_i;
	sqw_thresh_type     egress_tlp_count_i;
	logic [7:0]         src_req_i, grant_o, sbe_event_i;
	logic [2:0]         dest_port_i;
	int                 failures, checks_done, cycles, n;
	sqw_addr_type       za[6] = '{12'hf14, 12'hf18, 12'hf1c, 12'hf2c,
	                              12'hf30, 12'hf20};
	sqw_thresh_type     tc[6] = '{8'h1f, 8'h20, 8'h10, 8'h0f, 8'hff, 8'h00};
	logic               te[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

	sqw_regs #(.PORT_NUM(0), .IS_UPSTREAM(1'b1)) dut (
		.clk_i, .sys_rst_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_be_i,
		.cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .ee_wr_i, .ee_addr_i,
		.ee_data_i, .arb_load_i, .arb_weights_i, .egress_tlp_count_i,
		.egress_sched_en_o, .src_req_i, .dest_port_i, .tlp_done_i,
		.grant_o, .sbe_event_i, .inj_single_o, .inj_double_o, .inj_data_o
	);

	always #25 clk_i = ~clk_i;

	task automatic wrap_up();
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// generous ceiling; the whole sequence needs under 2000 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic wr(input sqw_addr_type a, input logic [31:0] d);
		@(negedge clk_i);
		cfg_wr_i = 1'b1;
		cfg_addr_i = a;
		cfg_wdata_i = d;
		@(negedge clk_i);
		cfg_wr_i = 1'b0;
	endtask

	// read data lands with ack at the take edge
	task automatic rd(input sqw_addr_type a, output logic [31:0] d);
		@(negedge clk_i);
		cfg_rd_i = 1'b1;
		cfg_addr_i = a;
		@(negedge clk_i);
		cfg_rd_i = 1'b0;
		@(negedge clk_i);
		d = cfg_rdata_o;
	endtask

	task automatic pulse_done();
		@(negedge clk_i);
		tlp_done_i = 1'b1;
		@(negedge clk_i);
		tlp_done_i = 1'b0;
	endtask

	task automatic pulse_sbe(input logic [7:0] m);
		@(negedge clk_i);
		sbe_event_i = m;
		@(negedge clk_i);
		sbe_event_i = 8'h00;
	endtask

	// a request pulse stands for the one cycle that begins at the edge after the write edge
	task automatic inj(input logic [31:0] d, input logic [3:0] s,
		input logic [3:0] b);
		wr(12'hf30, d);
		@(negedge clk_i);
		`CHK(inj_single_o, s)
		`CHK(inj_double_o, b)
		`CHK(inj_data_o, {d[11], d[8], d[5], d[2]})
		@(negedge clk_i);
		`CHK(inj_single_o | inj_double_o, 4'h0)
	endtask

	initial begin
		{clk_i, cfg_wr_i, cfg_rd_i, ee_wr_i, arb_load_i, tlp_done_i} = 6'h00;
		sys_rst_i = 1'b1;
		{cfg_addr_i, ee_addr_i} = 24'h000000;
		cfg_be_i = 4'hf;
		{cfg_wdata_i, ee_data_i} = 64'h0;
		arb_weights_i = 24'h000000;
		egress_tlp_count_i = 8'h00;
		{src_req_i, sbe_event_i} = 16'h0000;
		dest_port_i = 3'h7;
		{failures, checks_done, cycles} = 96'h0;
		repeat (20) @(negedge clk_i);
		sys_rst_i = 1'b0;
		rd(12'hf10, v);
		`CHK(v, 32'h00ff00ff)
		foreach (za[i]) begin
			rd(za[i], v);
			`CHK(v, 32'h00000000)
		end
		wr(12'hf14, 32'hffffffff);
		rd(12'hf14, v);
		`CHK(v, 32'h77777777)
		@(negedge clk_i);
		{ee_wr_i, ee_addr_i, ee_data_i} = {1'b1, 12'hf14, 32'h12345678};
		@(negedge clk_i);
		ee_wr_i = 1'b0;
		rd(12'hf14, v);
		`CHK(v, 32'h12345670)
		@(negedge clk_i);
		arb_weights_i = 24'hfac688;
		arb_load_i = 1'b1;
		@(negedge clk_i);
		arb_load_i = 1'b0;
		rd(12'hf14, v);
		`CHK(v, 32'h76543210)
		// slot 0 weight 2 gives three tlps, slot 1 weight 0 gives one;
		// the pick starts after slot 0, so slot 1 leads
		wr(12'hf14, 32'h00000002);
		src_req_i = 8'h03;
		n = 0;
		while (grant_o === 8'h00 && n < 8) begin
			@(negedge clk_i);
			n++;
		end
		`CHK(grant_o, 8'h02)
		pulse_done();
		`CHK(grant_o, 8'h00)
		@(negedge clk_i);
		`CHK(grant_o, 8'h01)
		repeat (2) begin
			pulse_done();
			`CHK(grant_o, 8'h01)
		end
		pulse_done();
		`CHK(grant_o, 8'h00)
		@(negedge clk_i);
		`CHK(grant_o, 8'h02)
		// slot 1 becomes the destination; only slot 0 may still win
		dest_port_i = 3'h1;
		repeat (3) @(negedge clk_i);
		`CHK(grant_o, 8'h01)
		src_req_i = 8'h00;
		wr(12'hf10, 32'hff20ff10);
		rd(12'hf10, v);
		`CHK(v, 32'h00200010)
		foreach (tc[i]) begin
			egress_tlp_count_i = tc[i];
			repeat (2) @(negedge clk_i);
			`CHK(egress_sched_en_o, te[i])
		end
		for (int i = 0; i < 8; i++)
			repeat (i + 1) pulse_sbe(8'h01 << i);
		rd(12'hf18, v);
		`CHK(v, 32'h04030201)
		rd(12'hf1c, v);
		`CHK(v, 32'h00000605)
		rd(12'hf2c, v);
		`CHK(v, 32'h08070000)
		repeat (260) pulse_sbe(8'h01);
		rd(12'hf18, v);
		`CHK(v, 32'h040302ff)
		v = 32'h0;
		for (int m = 0; m < 4; m++) begin
			v = v | (32'h5 << (3 * m));
			inj(v, 4'h1 << m, 4'h0);
			v = v ^ (32'h2 << (3 * m));
			inj(v, 4'h0, 4'h1 << m);
		end
		rd(12'hf30, w);
		`CHK(w, 32'h00000fff)
		inj(32'h000006db, 4'h0, 4'h0);
		wrap_up();
	end
endmodule
